/* hw/nac_ctrl.sv */
// cpu-side access controller for a 512-byte data nonvolatile array
// assumes same-clock cpu i/o strobes, an array that answers a read in the strobe cycle,
// a free-running 1 MHz oscillator pin and a power-on reset separate from system reset
`timescale 1ns/1ps
`include "nac_consts.svh"

module nac_ctrl
    import nac_pkg::*;
#(
    parameter int WR_OSC_CYC = `NAC_WR_OSC_CYC
)
(
    input  wire logic       sys_clk,       // cpu clock, 20 MHz
    input  wire logic       rstn,          // system reset, async, low
    input  wire logic       por_n,         // power-on reset, async, low
    input  wire logic       io_wr,         // i/o write strobe
    input  wire logic       io_rd,         // i/o read strobe
    input  wire logic [1:0] io_addr,       // register index
    input  wire logic [7:0] io_wdata,      // write data
    output logic      [7:0] io_rdata,      // read data, one cycle after io_rd
    input  wire logic       global_ie,     // cpu global interrupt enable
    input  wire logic       selfprog_busy, // flash self-programming active
    input  wire logic       osc_1mhz,      // calibrated oscillator pin
    input  wire logic [7:0] arr_rdata,     // array read data
    output logic      [8:0] arr_addr,      // array address
    output logic      [7:0] arr_wdata,     // array program data
    output logic            arr_rd,        // array read pulse
    output logic            arr_prog,      // array programming level
    output logic            cpu_stall,     // halts the cpu
    output logic            ready_irq      // ready interrupt level
);

    logic [8:0] nvm_address_reg_r;
    logic [7:0] nvm_data_reg_r;
    logic       ready_irq_enable_r;
    logic       master_write_arm_r;
    logic [2:0] arm_cnt_r;
    logic       start_r;
    logic [2:0] stall_cnt_r;
    logic [2:0] stall_nxt;
    logic       cpu_stall_r;
    logic       ready_irq_r;
    logic [7:0] io_rdata_r;
    logic       arr_rd_r;
    logic [8:0] arr_addr_r;
    logic [7:0] arr_wdata_r;
    logic       arr_prog_r;
    logic       osc_s1_r;
    logic       osc_s2_r;
    logic       osc_s3_r;
    logic       osc_edge;
    logic [13:0] osc_cnt_r;
    nac_eng_t   eng_st_r;
    nac_eng_t   eng_nxt;
    logic       busy_r;
    logic       ws_read;
    logic       ctrl_wr;
    logic       wr_go;
    logic       rd_go;

    // write strobe bit reads one from accept until the engine retires
    assign ws_read = busy_r | start_r;
    assign ctrl_wr = io_wr && (io_addr == `NAC_IDX_CTRL);

    // strobe only counts while armed, idle and flash quiet
    assign wr_go = ctrl_wr && io_wdata[`NAC_BIT_WS] && master_write_arm_r
                   && !ws_read && !selfprog_busy;
    // reads are refused while a write runs
    assign rd_go = ctrl_wr && io_wdata[`NAC_BIT_RS] && !ws_read;

    // address register, frozen while a write runs
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            nvm_address_reg_r <= 9'h000;
        else if (io_wr && !ws_read)
        begin
            if (io_addr == `NAC_IDX_ADDR_LO)
                nvm_address_reg_r[7:0] <= io_wdata;
            else if (io_addr == `NAC_IDX_ADDR_HI)
                nvm_address_reg_r[8] <= io_wdata[0];
        end
    end

    // data register: cpu writes, read results land the cycle after the array strobe
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            nvm_data_reg_r <= 8'h00;
        else if (arr_rd_r)
            nvm_data_reg_r <= arr_rdata;
        else if (io_wr && io_addr == `NAC_IDX_DATA)
            nvm_data_reg_r <= io_wdata;
    end

    // interrupt enable bit
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            ready_irq_enable_r <= 1'b0;
        else if (ctrl_wr)
            ready_irq_enable_r <= io_wdata[`NAC_BIT_RIE];
    end

    // arm bit with its four-cycle timeout; a fresh arm restarts the window
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            master_write_arm_r <= 1'b0;
            arm_cnt_r          <= 3'h0;
        end
        else if (ctrl_wr)
        begin
            master_write_arm_r <= io_wdata[`NAC_BIT_MWE];
            arm_cnt_r          <= `NAC_ARM_CYC - 3'h1;
        end
        else if (master_write_arm_r)
        begin
            if (arm_cnt_r == 3'h0)
                master_write_arm_r <= 1'b0;
            else
                arm_cnt_r <= arm_cnt_r - 3'h1;
        end
    end

    // one-cycle launch pulse toward the programming engine
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            start_r <= 1'b0;
        else
            start_r <= wr_go;
    end

    // stall counter: write costs two cycles, read four
    always_comb
    begin
        stall_nxt = stall_cnt_r;
        if (wr_go)
            stall_nxt = `NAC_WR_STALL_CYC;
        else if (rd_go)
            stall_nxt = `NAC_RD_STALL_CYC;
        else if (stall_cnt_r != 3'h0)
            stall_nxt = stall_cnt_r - 3'h1;
    end

    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            stall_cnt_r <= 3'h0;
            cpu_stall_r <= 1'b0;
        end
        else
        begin
            stall_cnt_r <= stall_nxt;
            cpu_stall_r <= (stall_nxt != 3'h0);
        end
    end

    // level interrupt, registered so the output is glitch free
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            ready_irq_r <= 1'b0;
        else
            ready_irq_r <= ready_irq_enable_r && global_ie && !ws_read;
    end

    // register read port; unused bits read zero
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            io_rdata_r <= 8'h00;
        else if (io_rd)
        begin
            if (io_addr == `NAC_IDX_ADDR_LO)
                io_rdata_r <= nvm_address_reg_r[7:0];
            else if (io_addr == `NAC_IDX_ADDR_HI)
                io_rdata_r <= {7'h00, nvm_address_reg_r[8]};
            else if (io_addr == `NAC_IDX_DATA)
                io_rdata_r <= nvm_data_reg_r;
            else
                io_rdata_r <= {4'h0, ready_irq_enable_r, master_write_arm_r, ws_read, 1'b0};
        end
    end

    // array read pulse
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
            arr_rd_r <= 1'b0;
        else
            arr_rd_r <= rd_go;
    end

    // the engine lives on power-on reset only, so a system reset cannot cut a write short
    always_ff @(posedge sys_clk or negedge por_n)
    begin
        if (!por_n)
        begin
            arr_addr_r  <= 9'h000;
            arr_wdata_r <= 8'h00;
        end
        else if (wr_go)
        begin
            arr_addr_r  <= nvm_address_reg_r;
            arr_wdata_r <= nvm_data_reg_r;
        end
        else if (rd_go)
            arr_addr_r <= nvm_address_reg_r;
    end

    // oscillator pin through two flops; third flop only for the edge
    always_ff @(posedge sys_clk or negedge por_n)
    begin
        if (!por_n)
        begin
            osc_s1_r <= 1'b0;
            osc_s2_r <= 1'b0;
            osc_s3_r <= 1'b0;
        end
        else
        begin
            osc_s1_r <= osc_1mhz;
            osc_s2_r <= osc_s1_r;
            osc_s3_r <= osc_s2_r;
        end
    end

    assign osc_edge = osc_s2_r && !osc_s3_r;

    // engine next state
    always_comb
    begin
        eng_nxt = eng_st_r;
        case (eng_st_r)
            NAC_IDLE:
                if (start_r)
                    eng_nxt = NAC_PROG;
            NAC_PROG:
                if (osc_edge && osc_cnt_r == 14'(WR_OSC_CYC - 1))
                    eng_nxt = NAC_DONE;
            NAC_DONE:
                eng_nxt = NAC_IDLE;
            default:
                eng_nxt = NAC_IDLE;
        endcase
    end

    // engine state, oscillator counter and programming level
    always_ff @(posedge sys_clk or negedge por_n)
    begin
        if (!por_n)
        begin
            eng_st_r   <= NAC_IDLE;
            osc_cnt_r  <= 14'h0000;
            busy_r     <= 1'b0;
            arr_prog_r <= 1'b0;
        end
        else
        begin
            eng_st_r   <= eng_nxt;
            busy_r     <= (eng_nxt != NAC_IDLE);
            arr_prog_r <= (eng_nxt == NAC_PROG);
            if (eng_st_r != NAC_PROG)
                osc_cnt_r <= 14'h0000;
            else if (osc_edge)
                osc_cnt_r <= osc_cnt_r + 14'h0001;
        end
    end

    assign io_rdata  = io_rdata_r;
    assign arr_addr  = arr_addr_r;
    assign arr_wdata = arr_wdata_r;
    assign arr_rd    = arr_rd_r;
    assign arr_prog  = arr_prog_r;
    assign cpu_stall = cpu_stall_r;
    assign ready_irq = ready_irq_r;

    // checks on the cpu side
    unarmed_strobe_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ctrl_wr && io_wdata[`NAC_BIT_WS] && !master_write_arm_r) |=> !start_r)
        else $error("strobe without arm started a write");

    armed_start_a: assert property (@(posedge sys_clk) disable iff (!rstn || !por_n)
        wr_go |=> start_r ##1 (busy_r && arr_prog_r))
        else $error("armed strobe did not start programming");

    arm_expire_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ctrl_wr && io_wdata[`NAC_BIT_MWE]) ##1 (!ctrl_wr)[*4] |=> !master_write_arm_r)
        else $error("arm bit outlived four cycles");

    arm_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ctrl_wr && io_wdata[`NAC_BIT_MWE]) ##1 (!ctrl_wr)[*3] |-> master_write_arm_r)
        else $error("arm bit dropped early");

    write_stall_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr_go |=> cpu_stall_r[*2] ##1 !cpu_stall_r)
        else $error("write stall not two cycles");

    read_stall_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        rd_go |=> cpu_stall_r[*4] ##1 !cpu_stall_r)
        else $error("read stall not four cycles");

    read_data_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        rd_go |=> arr_rd_r ##1 (nvm_data_reg_r == $past(arr_rdata)))
        else $error("read data not loaded");

    irq_level_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (ready_irq_enable_r && global_ie) |=> (ready_irq_r == !$past(ws_read)))
        else $error("ready irq does not follow write strobe");

    addr_freeze_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        ws_read |=> (nvm_address_reg_r == $past(nvm_address_reg_r)))
        else $error("address changed during write");

    flash_block_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        selfprog_busy |=> !start_r)
        else $error("write started during self-programming");

    prog_end_a: assert property (@(posedge sys_clk) disable iff (!por_n)
        (eng_st_r == NAC_DONE) |=> (!busy_r && !arr_prog_r))
        else $error("write strobe not cleared at end");

    reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (io_rd && io_addr == `NAC_IDX_CTRL) |=> (io_rdata_r[7:4] == 4'h0))
        else $error("reserved control bits not zero");

    irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (!ready_irq_enable_r || !global_ie) |=> !ready_irq_r)
        else $error("ready irq raised while disabled");

    addr_high_a: assert property (@(posedge sys_clk) disable iff (!rstn)
        (io_rd && io_addr == `NAC_IDX_ADDR_HI) |=> (io_rdata_r[7:1] == 7'h00))
        else $error("address high unused bits not zero");

endmodule // nac_ctrl

/* hw/nac_consts.svh */
// register indexes, field positions and timing counts of the nonvolatile access controller
// assumes the includer supplies a single cpu clock and the cpu i/o strobes
// Function
// - data register carries write byte, read result
// - control bits 7..4 read zero, ignore writes
// - bit 3 enables ready irq with global enable
// - ready irq level while write strobe reads zero
// - strobe within four cycles of arm starts write
// - strobe without arm does nothing
// - arm clears itself four cycles later
// - bit 1 is the write strobe
// - no write start while self-programming busy
// - hardware clears write strobe when time elapses
// - write start stalls cpu two cycles
// - read strobe loads data register at once
// - read strobe stalls cpu four cycles
// - no read, no address change while writing
// - write timed by 8448 oscillator cycles
// - write completes even across reset
// - nine-bit address, upper bits read zero
`ifndef NAC_CONSTS_SVH
`define NAC_CONSTS_SVH

`define NAC_IDX_ADDR_LO 2'h0
`define NAC_IDX_ADDR_HI 2'h1
`define NAC_IDX_DATA    2'h2
`define NAC_IDX_CTRL    2'h3

`define NAC_BIT_RIE 3
`define NAC_BIT_MWE 2
`define NAC_BIT_WS  1
`define NAC_BIT_RS  0

`define NAC_ARM_CYC      3'h4
`define NAC_WR_STALL_CYC 3'h2
`define NAC_RD_STALL_CYC 3'h4
`define NAC_WR_OSC_CYC   8448
`define NAC_WR_TIME_MS   8.5
`define NAC_OSC_HZ       1000000

`endif

/* hw/nac_pkg.sv */
// types shared by the nonvolatile access controller
// assumes nothing beyond the constants header
package nac_pkg;
    // programming engine states, gray along idle-prog-done
    typedef enum logic [1:0]
    {
        NAC_IDLE = 2'b00,
        NAC_PROG = 2'b01,
        NAC_DONE = 2'b11
    } nac_eng_t;
endpackage

/* verification/nac_array_model.sv */
// behavioural model of the byte array behind the access controller
// assumes the controller drives a registered address, a read pulse and a program level
`timescale 1ns/1ps

module nac_array_model
(
    input  wire logic       sys_clk,   // cpu clock
    input  wire logic [8:0] arr_addr,  // array address
    input  wire logic [7:0] arr_wdata, // program byte
    input  wire logic       arr_rd,    // read pulse
    input  wire logic       arr_prog,  // programming level
    output logic      [7:0] arr_rdata  // read data
);
    logic [7:0] mem [512];
    logic [7:0] last_q;
    logic       prog_q;

    // preload a known pattern so reads are checkable without prior writes
    initial
    begin
        for (int i = 0; i < 512; i++)
            mem[i] = i[7:0] ^ 8'h3C;
        last_q = 8'h00;
        prog_q = 1'b0;
    end

    // byte lands on the rising edge of the program level
    always @(posedge sys_clk)
    begin
        prog_q <= arr_prog;
        if (arr_prog && !prog_q)
            mem[arr_addr] <= arr_wdata;
        if (arr_rd)
            last_q <= mem[arr_addr];
    end

    // outside a read the bus shows the inverse, so stale data cannot pass
    assign arr_rdata = arr_rd ? mem[arr_addr] : ~last_q;

endmodule // nac_array_model

/* verification/tb_nac_ctrl.sv */
// self-checking bench for the nonvolatile access controller
// assumes the array model above and a free-running 1 MHz oscillator
`timescale 1ns/1ps

module tb_nac_ctrl;
    import nac_pkg::*;
    localparam int OSC_N = 4; // short programming time keeps the run brief
    logic       sys_clk = 0, rstn = 0, por_n = 0, io_wr = 0, io_rd = 0;
    logic       global_ie = 0, selfprog_busy = 0, osc_1mhz = 0;
    logic [1:0] io_addr = 2'h0;
    logic [7:0] io_wdata = 8'h00, io_rdata, arr_rdata, arr_wdata, v;
    logic [8:0] arr_addr, a, rd_addr;
    logic       arr_rd, arr_prog, cpu_stall, ready_irq, prog_seen;
    logic [7:0] shadow [512], d;
    int         error_cnt = 0, check_count = 0, stall_n, rd_n, seed = 20, prog_len = 0;
    logic       prog_q = 1'b0;

    always #25 sys_clk = ~sys_clk;
    always #500 osc_1mhz = ~osc_1mhz;

    // length of the last programming level, restarted on its rising edge
    always @(negedge sys_clk)
    begin
        prog_q <= (arr_prog === 1'b1);
        if (arr_prog === 1'b1)
            prog_len <= (prog_q ? prog_len : 0) + 1;
    end

    nac_ctrl #(.WR_OSC_CYC(OSC_N)) nac_ctrl_i (.sys_clk(sys_clk), .rstn(rstn), .por_n(por_n),
        .io_wr(io_wr), .io_rd(io_rd), .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .global_ie(global_ie), .selfprog_busy(selfprog_busy), .osc_1mhz(osc_1mhz),
        .arr_rdata(arr_rdata), .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rd(arr_rd),
        .arr_prog(arr_prog), .cpu_stall(cpu_stall), .ready_irq(ready_irq));
    nac_array_model nac_array_model_i (.sys_clk(sys_clk), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
        .arr_rd(arr_rd), .arr_prog(arr_prog), .arr_rdata(arr_rdata));

    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one register access; the design takes it on the second edge
    task automatic wr(input logic [1:0] idx, input logic [7:0] dat);
        @(posedge sys_clk);
        io_wr <= 1'b1;
        io_addr <= idx;
        io_wdata <= dat;
        @(posedge sys_clk);
        io_wr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] idx, output logic [7:0] val);
        @(posedge sys_clk);
        io_rd <= 1'b1;
        io_addr <= idx;
        @(posedge sys_clk);
        io_rd <= 1'b0;
        @(negedge sys_clk);
        val = io_rdata;
    endtask

    // counts stall cycles, read pulses and programming over a window
    task automatic observe(input int n);
        stall_n = 0;
        rd_n = 0;
        prog_seen = 1'b0;
        repeat (n)
        begin
            @(negedge sys_clk);
            stall_n += int'(cpu_stall === 1'b1);
            rd_n += int'(arr_rd === 1'b1);
            if (arr_rd === 1'b1)
                rd_addr = arr_addr;
            prog_seen |= (arr_prog === 1'b1);
        end
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (arr_prog !== 1'b0)
        begin
            @(negedge sys_clk);
            n++;
            if (n > 400)
            begin
                chk(16'h0, 16'h1);
                wrap_up();
            end
        end
        chk(16'(prog_len >= (OSC_N - 1) * 20 && prog_len <= (OSC_N + 2) * 20), 16'h1);
    endtask

    // full write sequence with the ready interrupt enable bit set
    task automatic do_write(input logic [8:0] wa, input logic [7:0] wd, input logic ok);
        wr(2'h0, wa[7:0]);
        wr(2'h1, {7'h00, wa[8]});
        wr(2'h2, wd);
        wr(2'h3, 8'h0C);
        wr(2'h3, 8'h0A);
        observe(8);
        chk({stall_n[7:0], 7'h00, prog_seen}, ok ? 16'h0201 : 16'h0000);
        if (ok)
        begin
            chk({7'h00, arr_addr}, {7'h00, wa});
            chk({8'h00, arr_wdata}, {8'h00, wd});
            shadow[wa] = wd;
        end
    endtask

    task automatic do_read(input logic [8:0] ra);
        wr(2'h0, ra[7:0]);
        wr(2'h1, {7'h00, ra[8]});
        wr(2'h3, 8'h01);
        observe(8);
        chk({stall_n[7:0], rd_n[7:0]}, 16'h0401);
        chk({7'h00, rd_addr}, {7'h00, ra});
        rd(2'h2, v);
        chk({8'h00, v}, {8'h00, shadow[ra]});
    endtask

    initial
    begin
        for (int i = 0; i < 512; i++)
            shadow[i] = i[7:0] ^ 8'h3C;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        por_n <= 1'b1;
        rd(2'h3, v);
        chk({8'h00, v}, 16'h0000);
        wr(2'h3, 8'hF0);
        rd(2'h3, v);
        chk({8'h00, v}, 16'h0000);
        wr(2'h1, 8'hFF);
        rd(2'h1, v);
        chk({8'h00, v}, 16'h0001);
        // strobe alone, then strobe after the arm has expired
        wr(2'h3, 8'h02);
        observe(8);
        chk({stall_n[7:0], 7'h00, prog_seen}, 16'h0000);
        wr(2'h3, 8'h04);
        rd(2'h3, v);
        chk({8'h00, v}, 16'h0004);
        repeat (6) @(posedge sys_clk);
        rd(2'h3, v);
        chk({8'h00, v}, 16'h0000);
        wr(2'h3, 8'h02);
        observe(8);
        chk({7'h00, prog_seen}, 16'h0000);
        selfprog_busy <= 1'b1;
        do_write(9'h005, 8'hA5, 1'b0);
        selfprog_busy <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            a = (k == 0) ? 9'h000 : (k == 1) ? 9'h1FF : 9'($random(seed));
            d = 8'($random(seed));
            do_write(a, d, 1'b1);
            rd(2'h3, v);
            chk({7'h00, ready_irq, v}, 16'h000A);
            wr(2'h0, ~a[7:0]);
            wr(2'h3, 8'h09);
            observe(8);
            chk({stall_n[7:0], rd_n[7:0]}, 16'h0000);
            wait_idle();
            rd(2'h3, v);
            chk({8'h00, v}, 16'h0008);
            global_ie <= 1'b1;
            observe(3);
            chk({15'h0000, ready_irq}, 16'h0001);
            global_ie <= 1'b0;
            observe(3);
            chk({15'h0000, ready_irq}, 16'h0000);
            do_read(a);
        end
        // system reset in mid-write must not abort programming
        do_write(9'h0AB, 8'h5E, 1'b1);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(2'h3, v);
        chk({7'h00, arr_prog, v & 8'h02}, 16'h0102);
        wait_idle();
        do_read(9'h0AB);
        wrap_up();
    end

endmodule // tb_nac_ctrl
